// *** bench/pcb_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module pcb_host_model (
	input wire logic clock,
	input wire logic [15:0] dataOut,
	input wire logic lowLaneOe,
	input wire logic highLaneOe,
	input wire logic ioWordCapable_n,
	output var pcb_pkg::pcb_pins_type pins,
	output var logic [10:0] addr,
	output var logic [15:0] dataIn
);
	import pcb_pkg::*;
	logic [15:0] drv = 16'h0000;
	logic [15:0] junk = 16'hA5C3;
	logic hostOe = 1'b0;
	logic wordCap = 1'b0;
	// a released lane keeps moving so a stale byte never passes as data
	always @(posedge clock) junk <= ~junk ^ 16'h0F01;
	assign dataIn = {highLaneOe ? dataOut[15:8] : hostOe ? drv[15:8]
		: junk[15:8], lowLaneOe ? dataOut[7:0] : hostOe ? drv[7:0]
		: junk[7:0]};
	initial begin
		pins = PINS_IDLE;
		addr = 11'h000;
	end
	////////////////////////////////////////////////////////////////
	// kind 0 io, 1 memory, 2 attribute, 3 io strobe with attribute high
	// ln is {high, low} lane enable; wordCap keeps the indication seen
	task automatic xfer(input int kind, input logic wr, input logic [1:0] ln,
		input logic [10:0] a, input logic [15:0] wd, output logic [17:0] rd);
		logic cap;
		int passes;
		@(negedge clock);
		pins.attrSel_n = kind[0];
		{pins.highLaneEnable_n, pins.lowLaneEnable_n} = ln;
		addr = a;
		drv = wd;
		hostOe = wr;
		// three cycles let word-capable settle before the strobe falls
		repeat (3) @(negedge clock);
		cap = !ioWordCapable_n;
		passes = (kind == 0 && ln == 2'b00 && !cap) ? 2 : 1;
		for (int p = 0; p < passes; p++) begin
			if (passes == 2) begin
				// no word-capable answer: even then odd byte cycle
				pins.attrSel_n = 1'b0;
				{pins.highLaneEnable_n, pins.lowLaneEnable_n} = 2'b10;
				addr = {a[10:1], p[0]};
				drv = p[0] ? {8'h00, wd[15:8]} : wd;
				hostOe = wr;
				repeat (3) @(negedge clock);
			end
			if (kind % 3 == 0)
				{pins.ioReadStrobe_n, pins.ioWriteStrobe_n} =
					wr ? 2'b10 : 2'b01;
			else
				{pins.memReadStrobe_n, pins.memWriteStrobe_n} =
					wr ? 2'b10 : 2'b01;
			repeat (5) @(negedge clock);
			rd[17:16] = p ? {lowLaneOe, rd[16]} : {highLaneOe, lowLaneOe};
			rd[15:0] = p ? {dataIn[7:0], rd[7:0]} : dataIn;
			pins = PINS_IDLE;
			hostOe = 1'b0;
			repeat (5) @(negedge clock);
		end
		wordCap = cap;
	endtask : xfer
endmodule : pcb_host_model
`default_nettype wire

// *** bench/pcb_port_sva.sv ***
`timescale 1ns/100ps
`default_nettype none
module pcb_port_sva (
	input wire logic clock,
	input wire logic rst,
	input wire pcb_pkg::pcb_pins_type pins,
	input wire logic [pcb_pkg::ADDR_W-1:0] addr,
	input wire logic [pcb_pkg::DATA_W-1:0] dataIn,
	input wire logic readyBusy,
	input wire logic writeProtect,
	input wire logic [pcb_pkg::DATA_W-1:0] dataOut,
	input wire logic lowLaneOe,
	input wire logic highLaneOe,
	input wire logic ioWordCapable_n,
	input wire logic readyChangeFlag,
	input wire logic wpChangeFlag
);
	import pcb_pkg::*;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	logic sb;
	logic rdHi;
	logic io_read_strobe_n;
	// four steady samples cover the whole synchroniser latency
	assign sb = pins.highLaneEnable_n & pins.lowLaneEnable_n;
	assign rdHi = pins.ioWriteStrobe_n & !pins.ioReadStrobe_n;
	assign io_read_strobe_n = !pins.attrSel_n & rdHi;
	a_standby_off: assert property (sb[*4]
		|=> !lowLaneOe && !highLaneOe)
		else $error("lane driven in standby");
	a_io_inhibit: assert property ((pins.attrSel_n
		&& pins.memReadStrobe_n && pins.memWriteStrobe_n)[*4]
		|=> !lowLaneOe && !highLaneOe)
		else $error("io strobe answered with attribute-select high");
	a_io_byte_rd: assert property ((io_read_strobe_n && pins.highLaneEnable_n
		&& !pins.lowLaneEnable_n)[*4] |=> lowLaneOe && !highLaneOe)
		else $error("io byte read on wrong lane");
	a_io_high_rd: assert property ((io_read_strobe_n && !pins.highLaneEnable_n
		&& pins.lowLaneEnable_n)[*4] |=> highLaneOe && !lowLaneOe)
		else $error("io high-only read on wrong lane");
	a_mem_word_rd: assert property ((pins.attrSel_n && !sb
		&& !pins.highLaneEnable_n && !pins.lowLaneEnable_n
		&& !pins.memReadStrobe_n && pins.memWriteStrobe_n)[*4]
		|=> lowLaneOe && highLaneOe)
		else $error("memory word read not on both lanes");
	a_mem_byte_rd: assert property ((pins.attrSel_n
		&& pins.highLaneEnable_n && !pins.lowLaneEnable_n
		&& !pins.memReadStrobe_n && pins.memWriteStrobe_n)[*4]
		|=> lowLaneOe && !highLaneOe)
		else $error("memory byte read on wrong lane");
	a_word_cap_on: assert property ((!pins.attrSel_n && !sb)[*4]
		|=> !ioWordCapable_n)
		else $error("word-capable not asserted");
	a_word_cap_off: assert property ((pins.attrSel_n || sb)[*4]
		|=> ioWordCapable_n)
		else $error("word-capable asserted without io selection");
	a_ready_chg: assert property ($changed(readyBusy)
		&& !$past(rst) |-> ##[1:3] readyChangeFlag)
		else $error("ready change not flagged");
	a_wp_chg: assert property ($changed(writeProtect)
		&& !$past(rst) |-> ##[1:3] wpChangeFlag)
		else $error("write-protect change not flagged");
endmodule : pcb_port_sva
`default_nettype wire

// *** bench/pcb_port_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module pcb_port_tb;
	import pcb_pkg::*;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic readyBusy = 1'b1;
	logic writeProtect = 1'b0;
	pcb_pins_type pins;
	logic [10:0] addr;
	logic [15:0] dataIn;
	logic [15:0] dataOut;
	logic lowLaneOe;
	logic highLaneOe;
	logic ioWordCapable_n;
	logic readyChangeFlag;
	logic wpChangeFlag;
	int fails = 0;
	int n_compared = 0;
	pcb_port pcb_port_i (.clock, .rst, .pins, .addr, .dataIn, .readyBusy,
		.writeProtect, .dataOut, .lowLaneOe, .highLaneOe, .ioWordCapable_n,
		.readyChangeFlag, .wpChangeFlag);
	pcb_host_model host_i (.clock, .dataOut, .lowLaneOe, .highLaneOe,
		.ioWordCapable_n, .pins, .addr, .dataIn);
	initial forever #20 clock = ~clock;
	////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// only driven lanes are judged; the others carry the model's moving junk
	task automatic rdc(input string what, input int kind, input logic [1:0] ln,
		input logic [10:0] a, input logic [1:0] eoe, input logic [15:0] ed);
		logic [17:0] r;
		logic [15:0] m;
		host_i.xfer(kind, 1'b0, ln, a, 16'h0000, r);
		m = {{8{eoe[1]}}, {8{eoe[0]}}};
		chk({what, " lanes"}, {14'h0000, eoe}, {14'h0000, r[17:16]});
		chk(what, ed & m, r[15:0] & m);
		chk({what, " wordCap"}, {15'h0000, !kind[0] && ln != 2'b11},
			{15'h0000, host_i.wordCap});
	endtask : rdc
	task automatic wr(input int kind, input logic [1:0] ln,
		input logic [10:0] a, input logic [15:0] d);
		logic [17:0] r;
		host_i.xfer(kind, 1'b1, ln, a, d, r);
		chk("wrWordCap", {15'h0000, !kind[0] && ln != 2'b11},
			{15'h0000, host_i.wordCap});
	endtask : wr
	task automatic t_regs;
		rdc("pinReg", 2, 2'b10, 11'h204, 2'b01, 16'h000E);
		wr(2, 2'b10, 11'h206, 16'h000F);
		rdc("socket", 2, 2'b10, 11'h206, 2'b01, 16'h0000);
		rdc("status", 2, 2'b10, 11'h202, 2'b01, 16'h0000);
		rdc("unmapped", 2, 2'b10, 11'h208, 2'b01, 16'h0000);
	endtask : t_regs
	task automatic t_flags;
		@(negedge clock);
		readyBusy = 1'b0;
		repeat (3) @(negedge clock);
		chk("rdyFlag", 16'h0001, {15'h0000, readyChangeFlag});
		rdc("status", 2, 2'b10, 11'h202, 2'b01, 16'h0080);
		rdc("pinReg", 2, 2'b10, 11'h204, 2'b01, 16'h002C);
		readyBusy = 1'b1;
		wr(2, 2'b10, 11'h204, 16'h0000);
		rdc("pinReg", 2, 2'b10, 11'h204, 2'b01, 16'h002E);
		wr(2, 2'b10, 11'h204, 16'h0003);
		rdc("pinReg", 2, 2'b10, 11'h204, 2'b01, 16'h000E);
		wr(2, 2'b10, 11'h204, 16'h0030);
		rdc("pinReg", 2, 2'b10, 11'h204, 2'b01, 16'h000E);
		writeProtect = 1'b1;
		repeat (3) @(negedge clock);
		chk("wpFlag", 16'h0001, {15'h0000, wpChangeFlag});
		rdc("pinReg", 2, 2'b10, 11'h204, 2'b01, 16'h001E);
		wr(2, 2'b10, 11'h204, 16'h0022);
		rdc("pinReg", 2, 2'b10, 11'h204, 2'b01, 16'h002E);
		chk("wpFlag", 16'h0000, {15'h0000, wpChangeFlag});
	endtask : t_flags
	task automatic t_io;
		wr(0, 2'b00, 11'h000, 16'hB47E);
		rdc("ioEven", 0, 2'b10, 11'h000, 2'b01, 16'h007E);
		rdc("ioOdd", 0, 2'b10, 11'h001, 2'b01, 16'h00B4);
		rdc("ioHigh", 0, 2'b01, 11'h000, 2'b10, 16'hB400);
		wr(0, 2'b10, 11'h000, 16'hE75A);
		wr(0, 2'b01, 11'h000, 16'hC3A9);
		wr(3, 2'b00, 11'h000, 16'hFFFF);
		rdc("ioWord", 0, 2'b00, 11'h000, 2'b11, 16'hC35A);
		wr(0, 2'b10, 11'h001, 16'h0096);
		rdc("ioWord", 0, 2'b00, 11'h000, 2'b11, 16'h965A);
		rdc("ioInhibit", 3, 2'b10, 11'h000, 2'b00, 16'h0000);
		rdc("standby", 0, 2'b11, 11'h000, 2'b00, 16'h0000);
	endtask : t_io
	task automatic t_mem;
		wr(1, 2'b00, 11'h013, 16'h91E6);
		rdc("memWord", 1, 2'b00, 11'h012, 2'b11, 16'h91E6);
		rdc("memOdd", 1, 2'b10, 11'h013, 2'b01, 16'h0091);
		wr(1, 2'b10, 11'h012, 16'h5A2D);
		wr(1, 2'b01, 11'h013, 16'h4B77);
		rdc("memWord", 1, 2'b00, 11'h012, 2'b11, 16'h4B2D);
		rdc("memEven", 1, 2'b10, 11'h012, 2'b01, 16'h002D);
		rdc("memHigh", 1, 2'b01, 11'h012, 2'b10, 16'h4B00);
	endtask : t_mem
	task automatic give_verdict;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : give_verdict
	initial begin
		repeat (12) @(negedge clock);
		rst = 1'b0;
		t_regs();
		t_flags();
		t_io();
		t_mem();
		give_verdict();
	end
	// a hang counts as a mismatch
	initial begin
		#200000;
		fails++;
		give_verdict();
	end
endmodule : pcb_port_tb
bind pcb_port pcb_port_sva pcb_port_sva_i (.clock, .rst, .pins, .addr,
	.dataIn, .readyBusy, .writeProtect, .dataOut, .lowLaneOe, .highLaneOe,
	.ioWordCapable_n, .readyChangeFlag, .wpChangeFlag);
`default_nettype wire

// *** design/pcb_lane_mem.sv ***
`timescale 1ns/100ps
`default_nettype none
module pcb_lane_mem (
	input wire logic clock,
	input wire logic writeEnable,
	input wire logic [1:0] byteEnable,
	input wire logic [pcb_pkg::MEM_ADDR_W-1:0] writeAddr,
	input wire logic [pcb_pkg::DATA_W-1:0] writeData,
	input wire logic [pcb_pkg::MEM_ADDR_W-1:0] readAddr,
	output var logic [pcb_pkg::DATA_W-1:0] readData
);
	import pcb_pkg::*;

	logic [DATA_W-1:0] words [MEM_WORDS];

	// each byte lane has its own write enable so byte cycles leave the
	// other half of the word untouched
	for (genvar lane = 0; lane < 2; lane++) begin : g_lane
		always_ff @(posedge clock) begin
			if (writeEnable && byteEnable[lane]) begin
				words[writeAddr][lane*8 +: 8] <= writeData[lane*8 +: 8];
			end
		end
	end

	always_ff @(posedge clock) begin
		readData <= words[readAddr];
	end

endmodule : pcb_lane_mem
`default_nettype wire

// *** design/pcb_pkg.sv ***
package pcb_pkg;

	localparam int ADDR_W = 11;
	localparam int DATA_W = 16;
	localparam int MEM_ADDR_W = 4;
	localparam int MEM_WORDS = 16;

	// attribute register block; all three registers sit from this base
	localparam logic [10:0] ATTR_BASE_ADDR = 11'h200;
	localparam logic [10:0] STATUS_INDEX = 11'h002;
	localparam logic [10:0] PIN_SUB_INDEX = 11'h004;
	localparam logic [10:0] SOCKET_INDEX = 11'h006;

	localparam int READY_FLAG_BIT = 5;
	localparam int WP_FLAG_BIT = 4;
	localparam int READY_MASK_BIT = 1;
	localparam int READY_LIVE_BIT = 1;
	localparam int CHANGED_BIT = 7;
	localparam logic [7:0] PIN_SUB_FIXED = 8'h0C;
	localparam logic FLAG_RESET = 1'b0;

	typedef struct packed {
		logic attrSel_n;
		logic highLaneEnable_n;
		logic lowLaneEnable_n;
		logic ioReadStrobe_n;
		logic ioWriteStrobe_n;
		logic memReadStrobe_n;
		logic memWriteStrobe_n;
	} pcb_pins_type;

	localparam pcb_pins_type PINS_IDLE = 7'h7F;

	typedef enum logic [3:0] {
		LANE_IDLE = 4'h1,
		LANE_LOW = 4'h2,
		LANE_HIGH = 4'h4,
		LANE_WORD = 4'h8
	} pcb_lane_type;

	typedef enum logic [6:0] {
		CYC_NONE = 7'h01,
		CYC_IO_RD = 7'h02,
		CYC_IO_WR = 7'h04,
		CYC_MEM_RD = 7'h08,
		CYC_MEM_WR = 7'h10,
		CYC_ATTR_RD = 7'h20,
		CYC_ATTR_WR = 7'h40
	} pcb_cycle_type;

	typedef struct packed {
		pcb_pins_type pinMeta;
		pcb_pins_type pinSync;
		pcb_pins_type pinPrev;
		logic [10:0] addrMeta;
		logic [10:0] addrSync;
		logic [10:0] addrPrev;
		logic [15:0] dataMeta;
		logic [15:0] dataSync;
		logic [15:0] dataPrev;
		logic primed;
		logic readyPrev;
		logic wpPrev;
		logic readyFlag;
		logic wpFlag;
		logic [15:0] dataOut;
		logic lowLaneOe;
		logic highLaneOe;
		logic ioWordCapable_n;
	} pcb_state_type;

endpackage : pcb_pkg

// *** design/pcb_port.sv ***
`timescale 1ns/100ps
`default_nettype none
module pcb_port (
	input wire logic clock,
	input wire logic rst,
	input wire pcb_pkg::pcb_pins_type pins,
	input wire logic [pcb_pkg::ADDR_W-1:0] addr,
	input wire logic [pcb_pkg::DATA_W-1:0] dataIn,
	input wire logic readyBusy,
	input wire logic writeProtect,
	output var logic [pcb_pkg::DATA_W-1:0] dataOut,
	output var logic lowLaneOe,
	output var logic highLaneOe,
	output var logic ioWordCapable_n,
	output var logic readyChangeFlag,
	output var logic wpChangeFlag
);
	import pcb_pkg::*;

	pcb_state_type state;
	pcb_state_type next_state;
	logic [DATA_W-1:0] memReadData;
	logic memWrite;
	logic [1:0] memByteEnable;
	logic [DATA_W-1:0] memWriteData;
	pcb_cycle_type prevCycle;
	pcb_cycle_type syncCycle;
	pcb_lane_type prevLane;
	logic writeEnded;
	logic readyToggle;
	logic wpToggle;
	logic [7:0] pinSubRead;
	logic [7:0] statusRead;

	////////////////////////////////////////////////////////////////////////
	// decoding helpers

	// lanes in use; both enables high is standby
	function automatic pcb_lane_type laneOf(input pcb_pins_type p);
		pcb_lane_type lane;
		lane = LANE_IDLE;
		if (!p.lowLaneEnable_n && !p.highLaneEnable_n) begin
			lane = LANE_WORD;
		end else if (!p.lowLaneEnable_n) begin
			lane = LANE_LOW;
		end else if (!p.highLaneEnable_n) begin
			lane = LANE_HIGH;
		end
		return lane;
	endfunction : laneOf

	function automatic pcb_cycle_type cycleOf(input pcb_pins_type p);
		pcb_cycle_type cyc;
		cyc = CYC_NONE;
		if (laneOf(p) == LANE_IDLE) begin
			cyc = CYC_NONE;
		end else if (p.attrSel_n) begin
			// io strobes are not looked at here
			if (!p.memReadStrobe_n) begin
				cyc = CYC_MEM_RD;
			end else if (!p.memWriteStrobe_n) begin
				cyc = CYC_MEM_WR;
			end
		end else if (!p.ioReadStrobe_n) begin
			cyc = CYC_IO_RD;
		end else if (!p.ioWriteStrobe_n) begin
			cyc = CYC_IO_WR;
		end else if (!p.memReadStrobe_n) begin
			cyc = CYC_ATTR_RD;
		end else if (!p.memWriteStrobe_n) begin
			cyc = CYC_ATTR_WR;
		end
		return cyc;
	endfunction : cycleOf

	function automatic logic isWrite(input pcb_cycle_type c);
		return (c == CYC_IO_WR) || (c == CYC_MEM_WR) || (c == CYC_ATTR_WR);
	endfunction : isWrite

	////////////////////////////////////////////////////////////////////////
	// storage behind the I/O and common memory windows

	pcb_lane_mem u_mem (
		.clock(clock),
		.writeEnable(memWrite),
		.byteEnable(memByteEnable),
		.writeAddr(state.addrPrev[MEM_ADDR_W:1]),
		.writeData(memWriteData),
		.readAddr(state.addrSync[MEM_ADDR_W:1]),
		.readData(memReadData)
	);

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		next_state = state;
		prevCycle = cycleOf(state.pinPrev);
		syncCycle = cycleOf(state.pinSync);
		prevLane = laneOf(state.pinPrev);
		// a write is acted on when its strobe is seen to end, using the last
		// sample taken while it was still active; settled data, one action
		writeEnded = isWrite(prevCycle) && (syncCycle != prevCycle);

		// pins pass two flops; the third stage is where cycles and lanes are decoded and write ends found
		next_state.pinMeta = pins;
		next_state.pinSync = state.pinMeta;
		next_state.pinPrev = state.pinSync;
		next_state.addrMeta = addr;
		next_state.addrSync = state.addrMeta;
		next_state.addrPrev = state.addrSync;
		next_state.dataMeta = dataIn;
		next_state.dataSync = state.dataMeta;
		next_state.dataPrev = state.dataSync;

		// primed stops a false change right after reset
		next_state.primed = 1'b1;
		next_state.readyPrev = readyBusy;
		next_state.wpPrev = writeProtect;
		readyToggle = state.primed && (readyBusy != state.readyPrev);
		wpToggle = state.primed && (writeProtect != state.wpPrev);
		next_state.readyFlag = state.readyFlag | readyToggle;
		next_state.wpFlag = state.wpFlag | wpToggle;

		pinSubRead = PIN_SUB_FIXED;
		pinSubRead[READY_FLAG_BIT] = state.readyFlag;
		pinSubRead[WP_FLAG_BIT] = state.wpFlag;
		pinSubRead[READY_LIVE_BIT] = state.readyPrev;
		statusRead = 8'h00;
		statusRead[CHANGED_BIT] = state.readyFlag | state.wpFlag;

		// memory write steering
		memWrite = writeEnded &&
			((prevCycle == CYC_IO_WR) || (prevCycle == CYC_MEM_WR));
		memByteEnable = 2'h0;
		memWriteData = state.dataPrev;
		case (prevLane)
			LANE_WORD: begin
				memByteEnable = 2'h3;
			end
			LANE_LOW: begin
				// low lane feeds whichever byte A0 names
				memByteEnable = state.addrPrev[0] ? 2'h2 : 2'h1;
				memWriteData = {state.dataPrev[7:0], state.dataPrev[7:0]};
			end
			LANE_HIGH: begin
				memByteEnable = 2'h2;
				memWriteData = {state.dataPrev[15:8], state.dataPrev[15:8]};
			end
			default: begin
				memByteEnable = 2'h0;
			end
		endcase

		// attribute register writes; only the low lane carries them
		if (writeEnded && (prevCycle == CYC_ATTR_WR)) begin
			if (state.addrPrev == ATTR_BASE_ADDR + PIN_SUB_INDEX) begin
				// bit 0 of the written byte is never looked at
				if (state.dataPrev[READY_MASK_BIT]) begin
					// a change in this same cycle still wins over the clear
					next_state.readyFlag =
						state.dataPrev[READY_FLAG_BIT] | readyToggle;
					next_state.wpFlag =
						state.dataPrev[WP_FLAG_BIT] | wpToggle;
				end
			end else if (state.addrPrev == ATTR_BASE_ADDR + SOCKET_INDEX) begin
				// socket and drive fields kept nowhere: one drive only
				next_state.primed = 1'b1;
			end
		end

		// read drive; data and enables leave the same flop stage
		next_state.dataOut = 16'h0000;
		next_state.lowLaneOe = 1'b0;
		next_state.highLaneOe = 1'b0;
		if ((prevCycle == CYC_IO_RD) || (prevCycle == CYC_MEM_RD)) begin
			case (prevLane)
				LANE_WORD: begin
					next_state.dataOut = memReadData;
					next_state.lowLaneOe = 1'b1;
					next_state.highLaneOe = 1'b1;
				end
				LANE_LOW: begin
					next_state.dataOut[7:0] = state.addrPrev[0] ?
						memReadData[15:8] : memReadData[7:0];
					next_state.lowLaneOe = 1'b1;
				end
				LANE_HIGH: begin
					next_state.dataOut[15:8] = memReadData[15:8];
					next_state.highLaneOe = 1'b1;
				end
				default: begin
					next_state.lowLaneOe = 1'b0;
				end
			endcase
		end else if (prevCycle == CYC_ATTR_RD) begin
			next_state.lowLaneOe = (prevLane != LANE_HIGH);
			if (state.addrPrev == ATTR_BASE_ADDR + PIN_SUB_INDEX) begin
				next_state.dataOut[7:0] = pinSubRead;
			end else if (state.addrPrev == ATTR_BASE_ADDR + STATUS_INDEX) begin
				next_state.dataOut[7:0] = statusRead;
			end else if (state.addrPrev == ATTR_BASE_ADDR + SOCKET_INDEX) begin
				next_state.dataOut[7:0] = 8'h00;
			end else begin
				next_state.dataOut[7:0] = 8'h00;
			end
		end

		// every decoded io address answers to both widths
		next_state.ioWordCapable_n = !(!state.pinSync.attrSel_n &&
			(laneOf(state.pinSync) != LANE_IDLE));

		if (rst) begin
			next_state = '0;
			next_state.pinMeta = PINS_IDLE;
			next_state.pinSync = PINS_IDLE;
			next_state.pinPrev = PINS_IDLE;
			next_state.readyFlag = FLAG_RESET;
			next_state.wpFlag = FLAG_RESET;
			next_state.ioWordCapable_n = 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		state <= next_state;
	end

	////////////////////////////////////////////////////////////////////////
	// outputs straight from the state flops

	always_comb begin
		dataOut = state.dataOut;
		lowLaneOe = state.lowLaneOe;
		highLaneOe = state.highLaneOe;
		ioWordCapable_n = state.ioWordCapable_n;
		readyChangeFlag = state.readyFlag;
		wpChangeFlag = state.wpFlag;
	end

endmodule : pcb_port
`default_nettype wire
